// ==== inc/brd_pkg.sv ====
// Behaviour
// - The generator keeps a 16-bit time constant built from two 8-bit registers, counts with a 17-bit down counter and drives a toggling output flop.
// - On start the output flop is forced high and the counter is loaded from the time constant.
// - At each zero count the output inverts and the counter reloads from the time constant.
// - Both bytes of the programmed time constant can be read back through two read registers.
// - A new time constant reaches the counter only at its next reload: at start, at zero count or on software reset.
// - The generator output may be driven on the auxiliary clock pin when neither transmit nor receive clock comes from it.
// - A source-select bit picks the primary clock pin at 0 and the bus clock at 1.
// - The generator runs while the enable bit is 1; hardware reset clears it, software reset keeps it.
// - The enable bit is synchronised to the generator clock at start-up, adding latency.
// - Clearing the enable bit stops the generator at once.
// - The output period is 2 times (time constant plus 2) source clock cycles.
// - Hardware reset selects the primary clock pin as the generator source.
package brd_pkg;
    // Widths
    localparam int TC_W = 16;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;

    // Register offsets
    localparam logic [4:0] TC_LOW_WR_OFFSET = 5'h0c;
    localparam logic [4:0] TC_HIGH_WR_OFFSET = 5'h0d;
    localparam logic [4:0] TC_LOW_RD_OFFSET = 5'h0c;
    localparam logic [4:0] TC_HIGH_RD_OFFSET = 5'h0d;
    localparam logic [4:0] MISC_CTRL_OFFSET = 5'h0e;
    localparam logic [4:0] STATUS_OFFSET = 5'h0f;
    localparam logic [4:0] AUX_CTRL_OFFSET = 5'h0b;

    // Field positions
    localparam int EN_BIT = 0;
    localparam int SRC_BIT = 1;
    localparam int AUX_OUT_BIT = 0;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_OUT_BIT = 1;
    localparam int ST_SRC_BIT = 2;
    localparam int ST_SYNC_BIT = 3;

    // Values after reset
    localparam logic [15:0] TC_RESET = 16'h0000;
    localparam logic EN_RESET = 1'b0;
    localparam logic SRC_RESET = 1'b0;
    localparam logic AUX_RESET = 1'b0;
    localparam logic OUT_RESET = 1'b1;

    // Generator clock edges spent synchronising the enable
    localparam logic [1:0] SYNC_TICKS = 2'h2;

    // Generator states
    typedef enum logic [2:0] {
        BRD_IDLE = 3'b001,
        BRD_SYNC = 3'b010,
        BRD_RUN = 3'b100
    } brd_state_type;
endpackage

// ==== inc/brd_gen_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Control side to counter core
interface brd_gen_if;
    logic tick;
    logic start;
    logic reload;
    logic run;
    logic [brd_pkg::TC_W-1:0] tc;
    logic [brd_pkg::TC_W:0] cnt;
    logic out;
    logic zero;
    modport ctl (output tick, start, reload, run, tc, input cnt, out, zero);
    modport gen (input tick, start, reload, run, tc, output cnt, out, zero);
endinterface
`default_nettype wire

// ==== logic/brd_divider_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module brd_divider_core (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Generator control and output
    brd_gen_if.gen gen
);
    logic [brd_pkg::TC_W:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic zero_q, zero_d;

    // Counter holds constant plus one, so each half period is constant plus two ticks
    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        zero_d = 1'b0;
        if (gen.start) begin
            cnt_d = {1'b0, gen.tc} + 17'h00001;
            out_d = 1'b1;
        end else if (gen.reload) begin
            cnt_d = {1'b0, gen.tc} + 17'h00001;
        end else if (gen.run && gen.tick) begin
            if (cnt_q == 17'h00000) begin
                out_d = ~out_q;
                cnt_d = {1'b0, gen.tc} + 17'h00001;
                zero_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 17'h00001;
            end
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q <= 17'h00000;
            out_q <= brd_pkg::OUT_RESET;
            zero_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
            zero_q <= zero_d;
        end
    end

    assign gen.cnt = cnt_q;
    assign gen.out = out_q;
    assign gen.zero = zero_q;
endmodule
`default_nettype wire

// ==== logic/brd_baud_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module brd_baud_divider (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic soft_rst,
    // Register port
    input wire logic [brd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [brd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [brd_pkg::DATA_W-1:0] reg_rdata,
    // Clock source pin
    input wire logic primary_clock_pin,
    // Channel clock selection
    input wire logic tx_clk_from_aux,
    input wire logic rx_clk_from_aux,
    output logic baud_clk,
    output logic baud_zero,
    // Auxiliary clock pin
    input wire logic aux_clk_i,
    output logic aux_clk_o,
    output logic aux_clk_oe_n
);
    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [brd_pkg::TC_W-1:0] tc_q, tc_d;
    logic en_q, en_d;
    logic src_q, src_d;
    logic aux_q, aux_d;
    logic [brd_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic [7:0] tc_lo;
    logic [7:0] tc_hi;
    logic [7:0] status;
    brd_pkg::brd_state_type state_q, state_d;
    brd_gen_if gen ();

    assign tc_lo = tc_q[7:0];
    assign tc_hi = tc_q[15:8];

    // Own state for software to see
    always_comb begin
        status = 8'h00;
        status[brd_pkg::ST_RUN_BIT] = gen.run;
        status[brd_pkg::ST_OUT_BIT] = gen.out;
        status[brd_pkg::ST_SRC_BIT] = src_q;
        status[brd_pkg::ST_SYNC_BIT] = (state_q == brd_pkg::BRD_SYNC);
    end

    // Writes go straight to the holding registers; counter sees them at reload only
    always_comb begin
        tc_d = tc_q;
        en_d = en_q;
        src_d = src_q;
        aux_d = aux_q;
        if (reg_wr) begin
            if (reg_addr == brd_pkg::TC_LOW_WR_OFFSET) begin
                tc_d[7:0] = reg_wdata;
            end else if (reg_addr == brd_pkg::TC_HIGH_WR_OFFSET) begin
                tc_d[15:8] = reg_wdata;
            end else if (reg_addr == brd_pkg::MISC_CTRL_OFFSET) begin
                en_d = reg_wdata[brd_pkg::EN_BIT];
                src_d = reg_wdata[brd_pkg::SRC_BIT];
            end else if (reg_addr == brd_pkg::AUX_CTRL_OFFSET) begin
                aux_d = reg_wdata[brd_pkg::AUX_OUT_BIT];
            end
        end
    end

    // Read data stands for one cycle only; unmapped and write-only read zero
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            if (reg_addr == brd_pkg::TC_LOW_RD_OFFSET) begin
                rdata_d = tc_lo;
            end else if (reg_addr == brd_pkg::TC_HIGH_RD_OFFSET) begin
                rdata_d = tc_hi;
            end else if (reg_addr == brd_pkg::STATUS_OFFSET) begin
                rdata_d = status;
            end else if (reg_addr == brd_pkg::AUX_CTRL_OFFSET) begin
                rdata_d = {7'h00, aux_q};
            end
        end
    end

    // Soft reset leaves every control bit alone
    always_ff @(posedge clock) begin
        if (rst) begin
            tc_q <= brd_pkg::TC_RESET;
            en_q <= brd_pkg::EN_RESET;
            src_q <= brd_pkg::SRC_RESET;
            aux_q <= brd_pkg::AUX_RESET;
            rdata_q <= 8'h00;
        end else begin
            tc_q <= tc_d;
            en_q <= en_d;
            src_q <= src_d;
            aux_q <= aux_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Source selection
    logic pin_q, pin_d;

    // Rising pin edges become ticks; no glitch hazard since the mux only gates ticks
    always_comb begin
        pin_d = primary_clock_pin;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign gen.tick = src_q ? 1'b1 : (primary_clock_pin & ~pin_q);

    ////////////////////////////////////////////////////////////////////////////
    // Start-up synchronisation
    logic [1:0] sync_q, sync_d;
    logic sync_done;

    assign sync_done = (sync_q == brd_pkg::SYNC_TICKS - 2'h1) && gen.tick;

    // Enable waits for generator ticks; disable bypasses the wait
    always_comb begin
        state_d = state_q;
        sync_d = sync_q;
        case (state_q)
            brd_pkg::BRD_IDLE: begin
                sync_d = 2'h0;
                if (en_q) begin
                    state_d = brd_pkg::BRD_SYNC;
                end
            end
            brd_pkg::BRD_SYNC: begin
                if (!en_q) begin
                    state_d = brd_pkg::BRD_IDLE;
                end else if (sync_done) begin
                    state_d = brd_pkg::BRD_RUN;
                end else if (gen.tick) begin
                    sync_d = sync_q + 2'h1;
                end
            end
            brd_pkg::BRD_RUN: begin
                if (!en_q) begin
                    state_d = brd_pkg::BRD_IDLE;
                end
            end
            default: begin
                state_d = brd_pkg::BRD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= brd_pkg::BRD_IDLE;
            sync_q <= 2'h0;
        end else begin
            state_q <= state_d;
            sync_q <= sync_d;
        end
    end

    assign gen.start = (state_q == brd_pkg::BRD_SYNC) && en_q && sync_done;
    assign gen.run = en_q && (state_q == brd_pkg::BRD_RUN);
    assign gen.reload = soft_rst;
    assign gen.tc = tc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Counter and outputs
    brd_divider_core u_core (
        .clock(clock),
        .rst(rst),
        .gen(gen.gen)
    );

    assign baud_clk = gen.out;
    assign baud_zero = gen.zero;
    assign aux_clk_o = gen.out;
    // Input side of the pin is left to the clock selection logic
    assign aux_clk_oe_n = ~(aux_q & ~tx_clk_from_aux & ~rx_clk_from_aux);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [brd_pkg::TC_W:0] gap_q, gap_d;
    logic [brd_pkg::TC_W:0] load_q, load_d;
    logic gap_ok_q, gap_ok_d;

    // Half-period measurement on the bus clock
    always_comb begin
        gap_d = gap_q + 17'h00001;
        load_d = load_q;
        gap_ok_d = gap_ok_q && src_q && gen.run && !soft_rst;
        if (gen.zero) begin
            gap_d = 17'h00001;
            load_d = gen.cnt;
            gap_ok_d = src_q && gen.run && !soft_rst;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gap_q <= 17'h00000;
            load_q <= 17'h00000;
            gap_ok_q <= 1'b0;
        end else begin
            gap_q <= gap_d;
            load_q <= load_d;
            gap_ok_q <= gap_ok_d;
        end
    end

    a_start_out_high: assert property (@(posedge clock) disable iff (rst)
        gen.start |=> gen.out && gen.cnt == {1'b0, $past(tc_q)} + 17'h00001)
        else $error("start did not force output high and load");
    a_zero_toggle: assert property (@(posedge clock) disable iff (rst)
        gen.zero |-> gen.out != $past(gen.out))
        else $error("output did not toggle at zero");
    a_zero_reload: assert property (@(posedge clock) disable iff (rst)
        gen.zero |-> gen.cnt == {1'b0, $past(tc_q)} + 17'h00001)
        else $error("counter not reloaded from constant");
    a_read_low: assert property (@(posedge clock) disable iff (rst)
        reg_rd && reg_addr == brd_pkg::TC_LOW_RD_OFFSET |=> reg_rdata == $past(tc_lo))
        else $error("low byte read-back wrong");
    a_read_high: assert property (@(posedge clock) disable iff (rst)
        reg_rd && reg_addr == brd_pkg::TC_HIGH_RD_OFFSET |=> reg_rdata == $past(tc_hi))
        else $error("high byte read-back wrong");
    a_write_low: assert property (@(posedge clock) disable iff (rst)
        reg_wr && reg_addr == brd_pkg::TC_LOW_WR_OFFSET |=> tc_lo == $past(reg_wdata))
        else $error("low byte write lost");
    a_stop_now: assert property (@(posedge clock) disable iff (rst)
        !en_q |-> !gen.run)
        else $error("generator runs while disabled");
    a_start_delay: assert property (@(posedge clock) disable iff (rst)
        $rose(en_q) && src_q |-> !gen.run [*3])
        else $error("start-up skipped synchronisation");
    a_half_period: assert property (@(posedge clock) disable iff (rst)
        gen.zero && gap_ok_q |-> gap_q == load_q + 17'h00001)
        else $error("half period is not constant plus two");
    a_reset_values: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> !src_q && !en_q)
        else $error("reset did not select pin and disable");
    a_aux_release: assert property (@(posedge clock) disable iff (rst)
        tx_clk_from_aux || rx_clk_from_aux |-> aux_clk_oe_n)
        else $error("aux pin driven while used as input");
    a_bus_tick: assert property (@(posedge clock) disable iff (rst)
        src_q && gen.run && !gen.start && !soft_rst |=> gen.cnt != $past(gen.cnt))
        else $error("bus clock source not counting");
endmodule
`default_nettype wire

// ==== testbench/brd_chan_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Channel clock selection stand-in: picks its clocks, times the generator
module brd_chan_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Generator side
    input wire logic baud_zero,
    input wire logic arm,
    input wire logic [1:0] aux_use,
    output logic tx_clk_from_aux,
    output logic rx_clk_from_aux,
    output logic [17:0] half_len,
    output logic half_vld
);
    logic seen_q;
    logic [17:0] cnt_q;
    // Clock choices are plain levels
    assign tx_clk_from_aux = aux_use[0];
    assign rx_clk_from_aux = aux_use[1];
    // Cycles between toggles; the first toggle only starts the count
    always_ff @(posedge clock) begin
        half_vld <= 1'b0;
        if (rst || !arm) begin
            seen_q <= 1'b0;
            cnt_q <= 18'h0;
        end else if (baud_zero) begin
            seen_q <= 1'b1;
            half_vld <= seen_q;
            half_len <= cnt_q;
            cnt_q <= 18'h1;
        end else begin
            cnt_q <= cnt_q + 18'h1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [4:0] TL = brd_pkg::TC_LOW_WR_OFFSET;
    localparam logic [4:0] TH = brd_pkg::TC_HIGH_WR_OFFSET;
    localparam logic [4:0] RL = brd_pkg::TC_LOW_RD_OFFSET;
    localparam logic [4:0] RH = brd_pkg::TC_HIGH_RD_OFFSET;
    localparam logic [4:0] MC = brd_pkg::MISC_CTRL_OFFSET;
    localparam logic [4:0] AX = brd_pkg::AUX_CTRL_OFFSET;
    logic clock, rst, soft_rst, reg_wr, reg_rd, rd_d, pin, pin_run, arm;
    logic baud_clk, baud_zero, aux_clk_o, aux_clk_oe_n, aux_pin, tx_aux, rx_aux, half_vld;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] aux_use;
    logic [17:0] half_len;
    logic [15:0] tc;
    logic [7:0] exp_rd[$];
    logic [17:0] exp_half[$];
    logic [4:0] rd_list[5] = '{RL, RH, AX, MC, 5'h1f};
    int n_errors = 0;
    int checks = 0;
    int k;

    // Pin is released high when the generator does not drive it
    assign aux_pin = aux_clk_oe_n ? 1'b1 : aux_clk_o;

    brd_baud_divider u_dut (.clock(clock), .rst(rst), .soft_rst(soft_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .primary_clock_pin(pin), .tx_clk_from_aux(tx_aux),
        .rx_clk_from_aux(rx_aux), .baud_clk(baud_clk), .baud_zero(baud_zero),
        .aux_clk_i(aux_pin), .aux_clk_o(aux_clk_o), .aux_clk_oe_n(aux_clk_oe_n));
    brd_chan_model u_chan (.clock(clock), .rst(rst), .baud_zero(baud_zero), .arm(arm),
        .aux_use(aux_use), .tx_clk_from_aux(tx_aux), .rx_clk_from_aux(rx_aux),
        .half_len(half_len), .half_vld(half_vld));

    ////////////////////////////////////////////////////////////////
    // Clock and pin source; pin toggles every cycle, rising edges every other cycle
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) if (pin_run) pin <= !pin;

    task automatic check(string name, logic [17:0] seen, logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(logic w, logic r, logic [4:0] a, logic [7:0] d);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic wr(logic [4:0] a, logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(logic [4:0] a, logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        exp_rd.push_back(e);
    endtask
    // Cycles until the next toggle pulse, bounded
    task automatic wait_zero(output int n);
        for (n = 0; n < 3000; n++) begin
            @(negedge clock);
            if (baud_zero === 1'b1) return;
        end
        n_errors++;
        conclude();
    endtask
    // Arm the timer, note the expected half periods, wait for them all
    task automatic measure(int len, int cnt);
        arm <= 1'b1;
        repeat (cnt) exp_half.push_back(18'(len));
        for (int i = 0; i < 5000 && exp_half.size() > 0; i++) @(posedge clock);
        if (exp_half.size() > 0) begin
            n_errors++;
            conclude();
        end
        arm <= 1'b0;
    endtask
    task automatic set_tc(logic [15:0] v);
        bus(1'b1, 1'b0, TL, v[7:0]);
        bus(1'b1, 1'b0, TH, v[15:8]);
        bus(1'b0, 1'b0, TH, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////
    // Result watcher: oldest note against each result
    always @(posedge clock) rd_d <= reg_rd;
    always @(negedge clock) begin
        if (rd_d) check("read data", reg_rdata, 18'(exp_rd.pop_front()));
        if (half_vld) check("half period", half_len, exp_half.pop_front());
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        {rst, soft_rst, reg_wr, reg_rd, pin, pin_run, arm} = 7'b1000000;
        {reg_addr, reg_wdata, aux_use, tc} = '0;
        k = $urandom(18581);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Reset state, unmapped and write-only reads give zero
        foreach (rd_list[i]) rd(rd_list[i], 8'h00);
        // Status after reset: stopped, output high, pin source
        rd(brd_pkg::STATUS_OFFSET, 8'h02);
        // Back-to-back byte writes and read-back of random constants
        repeat (4) begin
            tc = 16'($urandom);
            set_tc(tc);
            rd(RL, tc[7:0]);
            rd(RH, tc[15:8]);
        end
        // Bus clock source, constant written first, enable last
        tc = 16'($urandom_range(5, 1));
        set_tc(tc);
        wr(MC, 8'h02);
        wr(MC, 8'h03);
        measure(tc + 2, 3);
        // New constant while running waits for the reload
        // Disarm for one edge so the timer drops its old toggle
        @(posedge clock);
        arm <= 1'b1;
        wait_zero(k);
        set_tc(tc + 16'h3);
        measure(tc + 2, 1);
        arm <= 1'b1;
        measure(tc + 5, 2);
        // Channel reset keeps the generator running
        bus(1'b0, 1'b0, MC, 8'h00);
        soft_rst <= 1'b1;
        @(posedge clock);
        soft_rst <= 1'b0;
        measure(tc + 5, 2);
        // Stop at a low output, then restart from a forced high
        // Long enough half period that the stop lands before the next toggle
        wr(MC, 8'h02);
        set_tc(16'h0004);
        wr(MC, 8'h03);
        do wait_zero(k); while (baud_clk !== 1'b0);
        wr(MC, 8'h02);
        repeat (12) begin
            @(negedge clock);
            check("stopped", {baud_zero, baud_clk}, 18'h0);
        end
        wr(MC, 8'h03);
        wait_zero(k);
        // Enable edge, two sync ticks, start, then constant plus two ticks
        check("start delay", 18'(k), 18'h9);
        check("start level", baud_clk, 18'h0);
        // Auxiliary pin driven only when no channel clock uses it
        wr(AX, 8'h01);
        rd(AX, 8'h01);
        for (int u = 0; u < 4; u++) begin
            bus(1'b0, 1'b0, AX, 8'h00);
            aux_use <= 2'(u);
            @(negedge clock);
            check("aux drive", aux_clk_oe_n, 18'(u != 0));
            check("aux level", aux_pin, u != 0 ? 18'h1 : 18'(baud_clk));
        end
        // Hardware reset stops it; pin source needs no select write
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (10) begin
            @(negedge clock);
            check("reset idle", {baud_zero, baud_clk, aux_clk_oe_n}, 18'h3);
        end
        tc = 16'($urandom_range(3, 0));
        set_tc(tc);
        pin_run <= 1'b1;
        wr(MC, 8'h01);
        measure(2 * (tc + 2), 2);
        conclude();
    end
endmodule
`default_nettype wire
